// ===== core/arnf_pkg.sv
package arnf_pkg;
  localparam int          ADDR_W           = 12;
  localparam int          DATA_W           = 32;
  // Register byte offsets
  localparam logic [11:0] ASYNC_HI_SET_OFS = 12'h100;
  localparam logic [11:0] ASYNC_HI_CLR_OFS = 12'h104;
  localparam logic [11:0] ASYNC_LO_SET_OFS = 12'h108;
  localparam logic [11:0] ASYNC_LO_CLR_OFS = 12'h10C;
  localparam logic [11:0] PHYS_HI_SET_OFS  = 12'h110;
  localparam logic [11:0] PHYS_HI_CLR_OFS  = 12'h114;
  localparam logic [31:0] BITMAP_RST       = 32'h00000000;
  localparam logic [31:0] UNMAPPED_RDATA   = 32'h00000000;
  // Field layout
  localparam int          REMOTE_BUS_BIT   = 31;
  localparam logic [5:0]  HI_NODE_BASE     = 6'h20;
  localparam logic [5:0]  LAST_LOCAL_NODE  = 6'h3E;
  localparam logic [9:0]  LOCAL_BUS_ID     = 10'h3FF;
  // Bus answer phase
  typedef enum logic [1:0] {
    ARNF_IDLE = 2'b00,
    ARNF_ACK  = 2'b01
  } arnf_state_t;
endpackage : arnf_pkg

// ===== core/arnf_set_clear_reg.sv
`timescale 1ns/10ps
// One read/set/clear bitmap
module arnf_set_clear_reg #(
  parameter int          WIDTH    = 32,
  parameter logic [31:0] RST_VAL  = 32'h00000000
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Strobes
  input  wire logic             set_en,
  input  wire logic             clr_en,
  input  wire logic [WIDTH-1:0] wdata,
  // State
  output logic      [WIDTH-1:0] bits
);
  logic [WIDTH-1:0] bits_next;

  always_comb begin
    bits_next = bits;
    if (set_en) begin
      bits_next = bits | wdata;
    end else if (clr_en) begin
      bits_next = bits & ~wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bits <= RST_VAL[WIDTH-1:0];
    end else begin
      bits <= bits_next;
    end
  end
endmodule : arnf_set_clear_reg

// ===== core/arnf_filter.sv
`timescale 1ns/10ps
// Functional notes
// - High bits 19..0 accept nodes 51..32
// - Low bit n accepts node n
// - Low bitmap at set 108h, clear 10Ch
// - Low bitmap filters like the high one
// - Physical high bitmap, read/set/clear, resets zero
// - Zero filter bit: no ack, no queue
// - High bit 31 accepts remote bus requests
// - High bits 30..20 accept nodes 62..52
module arnf_filter (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Avalon-MM slave
  input  wire logic [11:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Incoming request check
  input  wire logic        req_valid,
  input  wire logic [15:0] req_src_id,
  output logic             req_accept,
  output logic             req_reject,
  // Filter state
  output logic      [31:0] async_low_bits,
  output logic      [31:0] async_high_bits,
  output logic      [31:0] phys_high_bits
);
  logic                 rst_s1_reg;
  logic                 rst_n_reg;
  arnf_pkg::arnf_state_t state_reg;
  arnf_pkg::arnf_state_t state_next;
  logic [31:0]          rdata_reg;
  logic [31:0]          rdata_next;
  logic                 accept_reg;
  logic                 accept_next;
  logic                 reject_reg;
  logic                 reject_next;
  logic                 wr_go;
  logic [5:0]           node;
  logic                 is_local;
  logic                 hit;

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg  <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg  <= rst_s1_reg;
    end
  end

  function automatic logic [31:0] arnf_read_mux(input logic [11:0] a,
                                                input logic [31:0] lo,
                                                input logic [31:0] hi,
                                                input logic [31:0] ph);
    case (a)
      arnf_pkg::ASYNC_HI_SET_OFS, arnf_pkg::ASYNC_HI_CLR_OFS: arnf_read_mux = hi;
      arnf_pkg::ASYNC_LO_SET_OFS, arnf_pkg::ASYNC_LO_CLR_OFS: arnf_read_mux = lo;
      arnf_pkg::PHYS_HI_SET_OFS, arnf_pkg::PHYS_HI_CLR_OFS:   arnf_read_mux = ph;
      default: arnf_read_mux = arnf_pkg::UNMAPPED_RDATA;
    endcase
  endfunction : arnf_read_mux

  // One wait state, then acknowledge
  always_comb begin
    state_next = state_reg;
    rdata_next = rdata_reg;
    case (state_reg)
      arnf_pkg::ARNF_IDLE: begin
        if (read || write) begin
          state_next = arnf_pkg::ARNF_ACK;
          rdata_next = arnf_read_mux(address, async_low_bits, async_high_bits,
                                     phys_high_bits);
        end
      end
      arnf_pkg::ARNF_ACK: state_next = arnf_pkg::ARNF_IDLE;
      default:            state_next = arnf_pkg::ARNF_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= arnf_pkg::ARNF_IDLE;
      rdata_reg <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      rdata_reg <= rdata_next;
    end
  end

  assign waitrequest = (read || write) && (state_reg != arnf_pkg::ARNF_ACK);
  assign readdata    = rdata_reg;
  assign wr_go       = write && (state_reg == arnf_pkg::ARNF_ACK);

  arnf_set_clear_reg #(.WIDTH(32), .RST_VAL(arnf_pkg::BITMAP_RST)) u_async_hi (
    .clk    (clk),
    .rst_n  (rst_n_reg),
    .set_en (wr_go && address == arnf_pkg::ASYNC_HI_SET_OFS),
    .clr_en (wr_go && address == arnf_pkg::ASYNC_HI_CLR_OFS),
    .wdata  (writedata),
    .bits   (async_high_bits)
  );

  arnf_set_clear_reg #(.WIDTH(32), .RST_VAL(arnf_pkg::BITMAP_RST)) u_async_lo (
    .clk    (clk),
    .rst_n  (rst_n_reg),
    .set_en (wr_go && address == arnf_pkg::ASYNC_LO_SET_OFS),
    .clr_en (wr_go && address == arnf_pkg::ASYNC_LO_CLR_OFS),
    .wdata  (writedata),
    .bits   (async_low_bits)
  );

  arnf_set_clear_reg #(.WIDTH(32), .RST_VAL(arnf_pkg::BITMAP_RST)) u_phys_hi (
    .clk    (clk),
    .rst_n  (rst_n_reg),
    .set_en (wr_go && address == arnf_pkg::PHYS_HI_SET_OFS),
    .clr_en (wr_go && address == arnf_pkg::PHYS_HI_CLR_OFS),
    .wdata  (writedata),
    .bits   (phys_high_bits)
  );

  // Source filter lookup
  assign node     = req_src_id[5:0];
  assign is_local = (req_src_id[15:6] == arnf_pkg::LOCAL_BUS_ID);

  always_comb begin
    hit = 1'b0;
    if (!is_local) begin
      hit = async_high_bits[arnf_pkg::REMOTE_BUS_BIT];
    end else if (node < arnf_pkg::HI_NODE_BASE) begin
      hit = async_low_bits[node[4:0]];
    end else if (node <= arnf_pkg::LAST_LOCAL_NODE) begin
      hit = async_high_bits[node[4:0]];
    end
  end

  always_comb begin
    accept_next = req_valid && hit;
    reject_next = req_valid && !hit;
  end

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      accept_reg <= 1'b0;
      reject_reg <= 1'b0;
    end else begin
      accept_reg <= accept_next;
      reject_reg <= reject_next;
    end
  end

  assign req_accept = accept_reg;
  assign req_reject = reject_reg;

  // Checks
  remote_bus_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    req_valid && req_src_id[15:6] != arnf_pkg::LOCAL_BUS_ID
      |=> req_accept == $past(async_high_bits[31]))
    else $error("remote bus decision wrong");
  low_node_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    req_valid && is_local && req_src_id[5] == 1'b0
      |=> req_accept == $past(async_low_bits[req_src_id[4:0]]))
    else $error("low node decision wrong");
  high_node_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    req_valid && is_local && req_src_id[5:0] >= 6'h20 && req_src_id[5:0] <= 6'h3E
      |=> req_accept == $past(async_high_bits[req_src_id[4:0]]))
    else $error("high node decision wrong");
  broadcast_drop_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    req_valid && is_local && req_src_id[5:0] == 6'h3F |=> req_reject)
    else $error("node 63 accepted");
  reject_ack_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    req_valid |=> req_accept != req_reject)
    else $error("verdict not unique");
  verdict_idle_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    !req_valid |=> !req_accept && !req_reject)
    else $error("verdict without request");
  low_set_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    wr_go && address == 12'h108 |=> (async_low_bits & $past(writedata)) == $past(writedata))
    else $error("low set failed");
  low_clear_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    wr_go && address == 12'h10C |=> (async_low_bits & $past(writedata)) == 32'h00000000)
    else $error("low clear failed");
  phys_hold_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    !wr_go |=> $stable(phys_high_bits))
    else $error("phys bitmap changed without write");
  low_hold_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    !(wr_go && (address == 12'h108 || address == 12'h10C)) |=> $stable(async_low_bits))
    else $error("low bitmap changed without write");
  bus_answer_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    (read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer late");
  accept_c: cover property (@(posedge clk) disable iff (!rst_n_reg) req_accept);
  reject_c: cover property (@(posedge clk) disable iff (!rst_n_reg) req_reject);
  clear_c:  cover property (@(posedge clk) disable iff (!rst_n_reg)
    wr_go && address == 12'h10C);
  remote_c: cover property (@(posedge clk) disable iff (!rst_n_reg)
    req_valid && !is_local && hit);
  phys_c:   cover property (@(posedge clk) disable iff (!rst_n_reg)
    wr_go && address == arnf_pkg::PHYS_HI_CLR_OFS);
  high_set_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    wr_go && address == arnf_pkg::ASYNC_HI_SET_OFS
      |=> (async_high_bits & $past(writedata)) == $past(writedata))
    else $error("high set failed");
  high_clear_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    wr_go && address == arnf_pkg::ASYNC_HI_CLR_OFS
      |=> (async_high_bits & $past(writedata)) == 32'h00000000)
    else $error("high clear failed");
  phys_set_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    wr_go && address == arnf_pkg::PHYS_HI_SET_OFS
      |=> (phys_high_bits & $past(writedata)) == $past(writedata))
    else $error("phys set failed");
  low_read_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    read && !waitrequest
      && (address == arnf_pkg::ASYNC_LO_SET_OFS || address == arnf_pkg::ASYNC_LO_CLR_OFS)
      |-> readdata == async_low_bits)
    else $error("low read data wrong");
  high_read_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    read && !waitrequest
      && (address == arnf_pkg::ASYNC_HI_SET_OFS || address == arnf_pkg::ASYNC_HI_CLR_OFS)
      |-> readdata == async_high_bits)
    else $error("high read data wrong");
  unmapped_read_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    read && !waitrequest && address[11:8] != 4'h1
      |-> readdata == arnf_pkg::UNMAPPED_RDATA)
    else $error("unmapped read not zero");
endmodule : arnf_filter

// ===== bench/arnf_node_model.sv
`timescale 1ns/10ps
// Remote node sending one-cycle requests
module arnf_node_model (
  // Clock
  input  wire logic        clk,
  // Request out
  output logic             req_valid,
  output logic      [15:0] req_src_id
);
  initial begin
    req_valid  = 1'b0;
    req_src_id = 16'h0000;
  end
  // Source ID is garbled once the pulse is over
  task automatic send(input logic [15:0] id);
    @(posedge clk);
    req_valid  <= 1'b1;
    req_src_id <= id;
    @(posedge clk);
    req_valid  <= 1'b0;
    req_src_id <= ~id;
  endtask : send
endmodule : arnf_node_model

// ===== bench/arnf_filter_bench.sv
`timescale 1ns/10ps
module arnf_filter_bench;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [15:0] s; logic acc;} arnf_row_t;
  logic        clk       = 1'b0;
  logic        rst_b     = 1'b0;
  logic [11:0] address   = 12'h000;
  logic        read      = 1'b0;
  logic        write     = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [31:0] readdata, lo_bits, hi_bits, ph_bits, rd;
  logic        waitrequest, req_valid, req_accept, req_reject;
  logic [15:0] req_src_id;
  int          mismatches = 0;
  int          checks     = 0;
  // Write, then one request and its expected verdict
  arnf_row_t   rows [12] = '{
    '{12'h100, 32'h00000000, 16'h0005, 1'b0}, '{12'h108, 32'h00000020, 16'hFFC5, 1'b1},
    '{12'h10C, 32'h00000020, 16'hFFC5, 1'b0}, '{12'h100, 32'h00080000, 16'hFFF3, 1'b1},
    '{12'h100, 32'h00000001, 16'hFFE0, 1'b1}, '{12'h100, 32'h40000000, 16'hFFFE, 1'b1},
    '{12'h100, 32'h00100000, 16'hFFF4, 1'b1}, '{12'h100, 32'h80000000, 16'h0005, 1'b1},
    '{12'h108, 32'h80000000, 16'hFFDF, 1'b1}, '{12'h108, 32'h00000001, 16'hFFC0, 1'b1},
    '{12'h104, 32'h40000000, 16'hFFFE, 1'b0}, '{12'h200, 32'hFFFFFFFF, 16'hFFFF, 1'b0}};
  always #25 clk = ~clk;
  arnf_filter uut (.clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .req_valid(req_valid), .req_src_id(req_src_id), .req_accept(req_accept),
    .req_reject(req_reject), .async_low_bits(lo_bits), .async_high_bits(hi_bits),
    .phys_high_bits(ph_bits));
  arnf_node_model node (.clk(clk), .req_valid(req_valid), .req_src_id(req_src_id));
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    address   <= a;
    writedata <= d;
    read      <= !wr;
    write     <= wr;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic req(input logic [15:0] s, input logic acc);
    node.send(s);
    @(negedge clk);
    cmp("verdict", {30'h0, acc, !acc}, {30'h0, req_accept, req_reject});
  endtask : req
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #100000;
    mismatches++;
    wrap_up();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d);
      req(rows[i].s, rows[i].acc);
    end
    bus(1'b0, 12'h100, 32'h0);
    cmp("high", 32'h80180001, rd);
    bus(1'b0, 12'h104, 32'h0);
    cmp("high clear port", 32'h80180001, rd);
    cmp("high bits", 32'h80180001, hi_bits);
    bus(1'b0, 12'h10C, 32'h0);
    cmp("low", 32'h80000001, rd);
    cmp("low bits", 32'h80000001, lo_bits);
    $display("rows done");
    bus(1'b1, 12'h110, 32'hA5A50F0F);
    bus(1'b1, 12'h114, 32'h00000F00);
    bus(1'b0, 12'h114, 32'h0);
    cmp("phys", 32'hA5A5000F, rd);
    cmp("phys bits", 32'hA5A5000F, ph_bits);
    bus(1'b1, 12'h200, 32'hFFFFFFFF);
    bus(1'b0, 12'h200, 32'h0);
    cmp("unmapped", 32'h0, rd);
    $display("phys done");
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    for (int k = 0; k < 3; k++) begin
      bus(1'b0, 12'h100 + 12'(k * 8), 32'h0);
      cmp("reset", 32'h0, rd);
    end
    cmp("reset bits", 32'h0, hi_bits | lo_bits | ph_bits);
    req(16'hFFDF, 1'b0);
    $display("reset done");
    wrap_up();
  end
endmodule : arnf_filter_bench
